// ===== inc/iacr_pkg.sv
// shared constants, register map and carrier types of the afe config bank
package iacr_pkg;
  // register addresses on the serial port
  localparam logic [6:0] ADDR_ANALOG_SETUP = 7'h04;
  localparam logic [6:0] ADDR_SAMPLING_SRC = 7'h05;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h06;
  localparam logic [6:0] ADDR_REVISION = 7'h07;
  localparam logic [6:0] ADDR_RED1_GAIN = 7'h08;
  localparam logic [6:0] ADDR_RED1_COARSE = 7'h09;
  localparam logic [6:0] ADDR_RED1_FINE_HI = 7'h0a;
  localparam logic [6:0] ADDR_RED1_FINE_LO = 7'h0b;
  localparam logic [6:0] ADDR_RED2_GAIN = 7'h0c;
  // reset values
  localparam logic [7:0] RST_ANALOG_SETUP = 8'h83;
  localparam logic [7:0] RST_SAMPLING_SRC = 8'hf7;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [4:0] RST_COARSE = 5'h10;
  localparam logic [7:0] RST_FINE_HI = 8'h80;
  localparam logic [2:0] RST_FINE_LO = 3'h0;
  // field positions
  localparam int ASC_DIVIDER = 7;
  localparam int ASC_REF_PD = 6;
  localparam int ASC_CLAMP_EDGE = 5;
  localparam int ASC_DIG_EDGE = 4;
  localparam int ASC_RANGE_HI = 3;
  localparam int ASC_RANGE_LO = 2;
  localparam int ASC_SH3_DIS = 1;
  localparam int ASC_DOUBLER = 0;
  localparam int SSC_DLL_SRC = 7;
  localparam int SRC_FSM_RESET = 1;
  localparam int SRC_REG_RESET = 0;
  localparam int FINE_LO_MSB = 7;
  localparam int FINE_LO_LSB = 5;
  // clock range codes
  localparam logic [1:0] RANGE_40_65 = 2'h0;
  localparam logic [1:0] RANGE_20_40 = 2'h1;
  // gain law numerator
  localparam logic [8:0] GAIN_NUMERATOR = 9'h11b;
  // serial frame: rw bit, 7 address bits, 8 data bits, msb first
  localparam logic [4:0] HEAD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  typedef enum logic [1:0]
  {
    SER_IDLE = 2'b00,
    SER_HEAD = 2'b01,
    SER_DATA = 2'b11
  } iacr_ser_state_t;

  typedef enum logic [1:0]
  {
    SEQ_HALT = 2'b00,
    SEQ_PH1 = 2'b01,
    SEQ_PH2 = 2'b11
  } iacr_seq_state_t;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } iacr_req_t;

  typedef struct packed
  {
    logic divider_en;
    logic ref_buf_pd;
    logic clamp_edge_fall;
    logic dig_edge_fall;
    logic [1:0] clock_range;
    logic sh3_disable;
    logic doubler;
    logic dll_source;
    logic [7:0] red1_gain;
    logic [4:0] red1_coarse;
    logic [10:0] red1_fine;
    logic [7:0] red2_gain;
  } iacr_cfg_t;
endpackage : iacr_pkg

// ===== src/iacr_serial_port.sv
// four-wire serial slave: frames bits into register requests
`timescale 1ns/1ps
module iacr_serial_port
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sen_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output iacr_pkg::iacr_req_t req_o,
  input wire logic [7:0] rdata_i
);
  import iacr_pkg::*;

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_d;
  logic [4:0] bit_cnt;
  logic [15:0] shreg;
  logic [7:0] out_sh;
  logic load_pend;
  iacr_ser_state_t state;
  logic sclk_rise;
  logic sclk_fall;
  logic in_frame;

  // two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // idle levels: serial clock low, enable high, data low, so no false edge
      sync_a <= 3'h2;
      sync_b <= 3'h2;
      sclk_d <= 1'b0;
    end
    else
    begin
      sync_a <= {sclk_i, sen_n_i, sdi_i};
      sync_b <= sync_a;
      sclk_d <= sync_b[2];
    end
  end

  assign sclk_rise = sync_b[2] & ~sclk_d;
  assign sclk_fall = ~sync_b[2] & sclk_d;
  assign in_frame = ~sync_b[1];

  // frame state and bit counting; enable high aborts any frame
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= SER_IDLE;
      bit_cnt <= 5'h00;
      shreg <= 16'h0000;
    end
    else if (!in_frame)
    begin
      state <= SER_IDLE;
      bit_cnt <= 5'h00;
    end
    else if (sclk_rise && bit_cnt != FRAME_BITS)
    begin
      shreg <= {shreg[14:0], sync_b[0]};
      bit_cnt <= bit_cnt + 5'h01;
      state <= (bit_cnt + 5'h01 >= HEAD_BITS) ? SER_DATA : SER_HEAD;
    end
    else if (state == SER_IDLE)
    begin
      state <= SER_HEAD;
    end
  end

  // request strobes: read after the header, write after the last bit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_o <= '0;
    end
    else
    begin
      req_o.rd <= in_frame && state == SER_HEAD && sclk_rise
        && bit_cnt == HEAD_BITS - 5'h01 && shreg[6];
      req_o.wr <= in_frame && state == SER_DATA && sclk_rise
        && bit_cnt == FRAME_BITS - 5'h01 && !shreg[14];
      // address held from the header on, so the read mux and the write see it
      if (in_frame && sclk_rise && bit_cnt == HEAD_BITS - 5'h01)
        req_o.addr <= {shreg[5:0], sync_b[0]};
      req_o.wdata <= {shreg[6:0], sync_b[0]};
    end
  end

  // read data out, shifted on falling edges after each data bit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_sh <= 8'h00;
      load_pend <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      load_pend <= req_o.rd;
      if (!in_frame)
        sdo_oe_o <= 1'b0;
      else if (load_pend)
        sdo_oe_o <= 1'b1;
      if (load_pend)
        out_sh <= rdata_i;
      else if (sclk_fall && bit_cnt > HEAD_BITS)
        out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  assign sdo_o = out_sh[7];
endmodule : iacr_serial_port

// ===== src/iacr_top.sv
// configuration register bank and timing front of a six-channel imaging afe
`timescale 1ns/1ps
module iacr_top
#(
  parameter int DIG_W = 4,
  // arbitrary revision value, not tied to any silicon
  parameter logic [7:0] REVISION_CODE = 8'h5c
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sen_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic mclk_i,
  input wire logic clamp_input_i,
  input wire logic [DIG_W-1:0] dig_in_i,
  input wire logic [1:0] sample_pulse_pins_i,
  output iacr_pkg::iacr_cfg_t cfg_o,
  output logic [8:0] gain_divisor_o,
  output logic clamp_sample_o,
  output logic [DIG_W-1:0] dig_sample_o,
  output logic converter_clock_en_o,
  output logic serial_tx_clock_en_o,
  output logic [1:0] sample_clk_o,
  output logic third_sample_hold_variant_o,
  output logic fsm_reset_o
);
  import iacr_pkg::*;

  iacr_req_t req;
  logic [7:0] rdata;
  logic [7:0] analog_setup_config;
  logic [7:0] sampling_source_config;
  logic [7:0] red1_pga_gain;
  logic [4:0] red1_coarse_offset;
  logic [7:0] red1_fine_offset_high;
  logic [2:0] red1_fine_offset_low;
  logic [7:0] red2_pga_gain;
  logic soft_fsm_pulse;
  logic soft_reg_pulse;
  logic fsm_clear;
  logic [DIG_W+3:0] pin_s1;
  logic [DIG_W+3:0] pin_s2;
  logic mclk_d;
  logic mclk_rise;
  logic mclk_fall;
  logic clamp_edge;
  logic dig_edge;
  logic conv_tick;
  logic [1:0] pins_d;
  iacr_seq_state_t seq_state;
  iacr_seq_state_t next_seq_state;

  // serial interface stays outside every soft reset
  iacr_serial_port u_serial
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sclk_i(sclk_i),
    .sen_n_i(sen_n_i),
    .sdi_i(sdi_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .req_o(req),
    .rdata_i(rdata)
  );

  // soft reset writes become one-cycle pulses, nothing is stored
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      soft_fsm_pulse <= 1'b0;
      soft_reg_pulse <= 1'b0;
    end
    else
    begin
      soft_fsm_pulse <= req.wr && req.addr == ADDR_SOFT_RESET
        && req.wdata[SRC_FSM_RESET];
      soft_reg_pulse <= req.wr && req.addr == ADDR_SOFT_RESET
        && req.wdata[SRC_REG_RESET];
    end
  end

  // a register reset also restarts the state machines
  assign fsm_clear = soft_fsm_pulse | soft_reg_pulse;
  assign fsm_reset_o = fsm_clear;

  // main configuration registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      analog_setup_config <= RST_ANALOG_SETUP;
      sampling_source_config <= RST_SAMPLING_SRC;
    end
    else if (soft_reg_pulse)
    begin
      analog_setup_config <= RST_ANALOG_SETUP;
      sampling_source_config <= RST_SAMPLING_SRC;
    end
    else if (req.wr)
    begin
      if (req.addr == ADDR_ANALOG_SETUP)
        analog_setup_config <= req.wdata;
      // reserved low bits kept as written; host keeps them at default
      if (req.addr == ADDR_SAMPLING_SRC)
        sampling_source_config <= req.wdata;
    end
  end

  // red channel gain and offset groups
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      red1_pga_gain <= RST_GAIN;
      red1_coarse_offset <= RST_COARSE;
      red1_fine_offset_high <= RST_FINE_HI;
      red1_fine_offset_low <= RST_FINE_LO;
      red2_pga_gain <= RST_GAIN;
    end
    else if (soft_reg_pulse)
    begin
      red1_pga_gain <= RST_GAIN;
      red1_coarse_offset <= RST_COARSE;
      red1_fine_offset_high <= RST_FINE_HI;
      red1_fine_offset_low <= RST_FINE_LO;
      red2_pga_gain <= RST_GAIN;
    end
    else if (req.wr)
    begin
      case (req.addr)
        ADDR_RED1_GAIN: red1_pga_gain <= req.wdata;
        ADDR_RED1_COARSE: red1_coarse_offset <= req.wdata[4:0];
        ADDR_RED1_FINE_HI: red1_fine_offset_high <= req.wdata;
        ADDR_RED1_FINE_LO: red1_fine_offset_low <= req.wdata[FINE_LO_MSB:FINE_LO_LSB];
        ADDR_RED2_GAIN: red2_pga_gain <= req.wdata;
        default: ;
      endcase
    end
  end

  // read mux; soft reset reads zero, revision ignores writes
  always_comb
  begin
    rdata = 8'h00;
    case (req.addr)
      ADDR_ANALOG_SETUP: rdata = analog_setup_config;
      ADDR_SAMPLING_SRC: rdata = sampling_source_config;
      ADDR_SOFT_RESET: rdata = 8'h00;
      ADDR_REVISION: rdata = REVISION_CODE;
      ADDR_RED1_GAIN: rdata = red1_pga_gain;
      ADDR_RED1_COARSE: rdata = {3'h0, red1_coarse_offset};
      ADDR_RED1_FINE_HI: rdata = red1_fine_offset_high;
      ADDR_RED1_FINE_LO: rdata = {red1_fine_offset_low, 5'h00};
      ADDR_RED2_GAIN: rdata = red2_pga_gain;
      default: rdata = 8'h00;
    endcase
  end

  // configuration fields out to the analog side
  always_comb
  begin
    cfg_o.divider_en = analog_setup_config[ASC_DIVIDER];
    cfg_o.ref_buf_pd = analog_setup_config[ASC_REF_PD];
    cfg_o.clamp_edge_fall = analog_setup_config[ASC_CLAMP_EDGE];
    cfg_o.dig_edge_fall = analog_setup_config[ASC_DIG_EDGE];
    cfg_o.clock_range = analog_setup_config[ASC_RANGE_HI:ASC_RANGE_LO];
    cfg_o.sh3_disable = analog_setup_config[ASC_SH3_DIS];
    cfg_o.doubler = analog_setup_config[ASC_DOUBLER];
    cfg_o.dll_source = sampling_source_config[SSC_DLL_SRC];
    cfg_o.red1_gain = red1_pga_gain;
    cfg_o.red1_coarse = red1_coarse_offset;
    cfg_o.red1_fine = {red1_fine_offset_high, red1_fine_offset_low};
    cfg_o.red2_gain = red2_pga_gain;
  end

  // variant enable is active when the disable bit is clear
  assign third_sample_hold_variant_o = ~analog_setup_config[ASC_SH3_DIS];

  // gain divisor, a registered data output
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gain_divisor_o <= GAIN_NUMERATOR;
    else
      gain_divisor_o <= GAIN_NUMERATOR - {1'b0, red1_pga_gain};
  end

  // pin synchronisers for master clock, clamp, digital and pulse pins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= {sample_pulse_pins_i, dig_in_i, clamp_input_i, mclk_i};
      pin_s2 <= pin_s1;
    end
  end

  // master clock edge finder; the state machine reset loads the same level as normal operation
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mclk_d <= 1'b0;
    else if (fsm_clear)
      mclk_d <= pin_s2[0];
    else
      mclk_d <= pin_s2[0];
  end

  assign mclk_rise = pin_s2[0] & ~mclk_d;
  assign mclk_fall = ~pin_s2[0] & mclk_d;
  assign clamp_edge = cfg_o.clamp_edge_fall ? mclk_fall : mclk_rise;
  assign dig_edge = cfg_o.dig_edge_fall ? mclk_fall : mclk_rise;

  // input capture on the chosen master clock edges
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clamp_sample_o <= 1'b0;
      dig_sample_o <= '0;
    end
    else if (fsm_clear)
    begin
      clamp_sample_o <= 1'b0;
      dig_sample_o <= '0;
    end
    else
    begin
      if (clamp_edge)
        clamp_sample_o <= pin_s2[1];
      if (dig_edge)
        dig_sample_o <= pin_s2[DIG_W+1:2];
    end
  end

  // doubler ticks on both master edges, else on the rising one only;
  // the sampled clock limits the doubled rate to well below clock_i
  assign conv_tick = cfg_o.doubler ? (mclk_rise | mclk_fall) : mclk_rise;

  // one tick feeds both enables so they can never drift apart
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      converter_clock_en_o <= 1'b0;
      serial_tx_clock_en_o <= 1'b0;
    end
    else
    begin
      converter_clock_en_o <= conv_tick & ~fsm_clear;
      serial_tx_clock_en_o <= conv_tick & ~fsm_clear;
    end
  end

  // internal sampling sequencer: two phases per pixel, so the
  // converter rate is twice the pixel rate in six-channel mode
  always_comb
  begin
    next_seq_state = seq_state;
    case (seq_state)
      SEQ_HALT: if (cfg_o.dll_source) next_seq_state = SEQ_PH1;
      SEQ_PH1: if (!cfg_o.dll_source) next_seq_state = SEQ_HALT;
        else if (conv_tick) next_seq_state = SEQ_PH2;
      SEQ_PH2: if (!cfg_o.dll_source) next_seq_state = SEQ_HALT;
        else if (conv_tick) next_seq_state = SEQ_PH1;
      default: next_seq_state = SEQ_HALT;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seq_state <= SEQ_HALT;
    else if (fsm_clear)
      seq_state <= SEQ_HALT;
    else
      seq_state <= next_seq_state;
  end

  // sampling clock source select
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pins_d <= 2'h0;
      sample_clk_o <= 2'h0;
    end
    else
    begin
      pins_d <= pin_s2[DIG_W+3:DIG_W+2];
      if (cfg_o.dll_source)
        sample_clk_o <= {seq_state == SEQ_PH2, seq_state == SEQ_PH1};
      else
        sample_clk_o <= pins_d;
    end
  end
endmodule : iacr_top

// ===== bench/iacr_chk_properties.sv
// assertion checker bound to the afe config bank top
`timescale 1ns/1ps
module iacr_chk
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic mclk_i,
  input wire iacr_pkg::iacr_cfg_t cfg_o,
  input wire logic [8:0] gain_divisor_o,
  input wire logic clamp_sample_o,
  input wire logic converter_clock_en_o,
  input wire logic serial_tx_clock_en_o,
  input wire logic third_sample_hold_variant_o,
  input wire logic fsm_reset_o
);
  import iacr_pkg::*;
  logic mclk_q;
  logic [3:0] rise_age;
  logic [3:0] fr_age;
  // cycles since the raw master clock last rose
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mclk_q <= 1'b0;
      rise_age <= 4'hf;
    end
    else
    begin
      mclk_q <= mclk_i;
      if (mclk_i && !mclk_q)
        rise_age <= 4'h0;
      else if (rise_age != 4'hf)
        rise_age <= rise_age + 4'h1;
    end
  end
  // a state machine reset may swallow a pending tick, so mute for a while
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fr_age <= 4'hf;
    else if (fsm_reset_o)
      fr_age <= 4'h0;
    else if (fr_age != 4'hf)
      fr_age <= fr_age + 4'h1;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i || fsm_reset_o || fr_age < 4'ha);
  sequence s_tick;
    ##[1:6] converter_clock_en_o;
  endsequence
  sequence s_dbl_fall;
    cfg_o.doubler [*4] ##0 $fell(mclk_i);
  endsequence
  sequence s_rise_capture;
    (!cfg_o.clamp_edge_fall) [*8] ##0 $changed(clamp_sample_o);
  endsequence
  AST_DIV: assert property (gain_divisor_o == GAIN_NUMERATOR - {1'b0, $past(cfg_o.red1_gain)})
    else $error("gain divisor does not follow gain code");
  AST_TXEQ: assert property (serial_tx_clock_en_o == converter_clock_en_o)
    else $error("transmit and converter ticks differ");
  AST_TICK: assert property ($rose(mclk_i) |-> s_tick)
    else $error("no converter tick after master clock rise");
  AST_DBL: assert property (s_dbl_fall |-> ##[1:6] (converter_clock_en_o || !cfg_o.doubler))
    else $error("doubler gave no tick on master clock fall");
  AST_SH3: assert property (third_sample_hold_variant_o != cfg_o.sh3_disable)
    else $error("third variant enable not inverse of its bit");
  AST_FSMR: assert property (disable iff (!rst_n_i) fsm_reset_o |=> !fsm_reset_o)
    else $error("state machine reset longer than one cycle");
  AST_CLAMP: assert property (s_rise_capture |-> rise_age < 4'h7)
    else $error("clamp captured away from master clock rise");
  AST_RST: assert property ($rose(rst_n_i) |-> cfg_o.red1_coarse == RST_COARSE
    && cfg_o.red1_fine == {RST_FINE_HI, RST_FINE_LO})
    else $error("offset codes not at reset values");
endmodule : iacr_chk

bind iacr_top iacr_chk iacr_chk_inst
(
  .clock_i,
  .rst_n_i,
  .mclk_i,
  .cfg_o,
  .gain_divisor_o,
  .clamp_sample_o,
  .converter_clock_en_o,
  .serial_tx_clock_en_o,
  .third_sample_hold_variant_o,
  .fsm_reset_o
);

// ===== bench/iacr_host_model.sv
// host side of the four-wire serial port
`timescale 1ns/1ps
module iacr_host_model
(
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic sen_n_o,
  output logic sdi_o
);
  // serial clock stands low outside frames
  initial
  begin
    sclk_o = 1'b0;
    sen_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // half a serial clock period, four system cycles
  task automatic half();
    repeat (4) @(posedge clock_i);
    #2;
  endtask : half
  // one frame msb first; read bits taken late in the high phase
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [15:0] f;
    f = {rw, a, d};
    sen_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_o = f[i];
      half();
      sclk_o = 1'b1;
      half();
      if (i < 8)
        q[i] = sdo_i;
      sclk_o = 1'b0;
    end
    half();
    sen_n_o = 1'b1;
    sdi_o = ~f[0]; // released line shows the other level
    repeat (6) @(posedge clock_i);
    #2;
  endtask : xfer
endmodule : iacr_host_model

// ===== bench/imaging_afe_config_regs_bench.sv
// self-checking bench for the afe config bank
`timescale 1ns/1ps
module imaging_afe_config_regs_bench;
  import iacr_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary revision value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mclk = 1'b0;
  logic clamp_in = 1'b0;
  logic [3:0] dig_in = 4'ha;
  logic [1:0] pins = 2'b00;
  logic sclk;
  logic sen_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  iacr_cfg_t cfg;
  logic [8:0] gdiv;
  logic clamp_s;
  logic [3:0] dig_s;
  logic conv_en;
  logic tx_en;
  logic [1:0] sclk_out;
  logic sh3v;
  logic fsm_rst;
  int errors = 0;
  int samples_checked = 0;
  int fsm_pulses = 0;
  wire logic sdo_line = sdo_oe ? sdo : 1'bz;

  iacr_top #(.REVISION_CODE(REV)) iacr_top_inst
  (
    .clock_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .sen_n_i(sen_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .mclk_i(mclk), .clamp_input_i(clamp_in),
    .dig_in_i(dig_in), .sample_pulse_pins_i(pins), .cfg_o(cfg), .gain_divisor_o(gdiv),
    .clamp_sample_o(clamp_s), .dig_sample_o(dig_s), .converter_clock_en_o(conv_en),
    .serial_tx_clock_en_o(tx_en), .sample_clk_o(sclk_out),
    .third_sample_hold_variant_o(sh3v), .fsm_reset_o(fsm_rst)
  );
  iacr_host_model iacr_host_model_inst
  (
    .clock_i(clk), .sdo_i(sdo_line), .sclk_o(sclk), .sen_n_o(sen_n), .sdi_o(sdi)
  );

  // system clock, and a master clock of exactly sixteen cycles
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #22;
    forever #320 mclk = ~mclk;
  end
  // count state machine reset pulses
  always @(posedge clk)
  begin
    if (fsm_rst === 1'b1)
      fsm_pulses++;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    iacr_host_model_inst.xfer(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    iacr_host_model_inst.xfer(1'b1, a, 8'h00, q);
    cmp(q, exp);
  endtask : rd
  // whole map after reset, unmapped neighbours on each side
  task automatic t_defaults();
    logic [7:0] tab [0:10];
    tab = '{8'h00, 8'h83, 8'hf7, 8'h00, REV, 8'h00, 8'h10, 8'h80, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 11; i++)
      rd(7'h03 + 7'(i), tab[i]);
    cmp(gdiv, GAIN_NUMERATOR);
  endtask : t_defaults
  task automatic t_access();
    wr(ADDR_REVISION, 8'hff);
    rd(ADDR_REVISION, REV);
    wr(ADDR_RED1_COARSE, 8'hff);
    rd(ADDR_RED1_COARSE, 8'h1f);
    wr(ADDR_RED1_FINE_HI, 8'h5a);
    wr(ADDR_RED1_FINE_LO, 8'hff);
    rd(ADDR_RED1_FINE_LO, 8'he0);
    cmp(cfg.red1_fine, {8'h5a, 3'h7});
    wr(ADDR_RED1_GAIN, 8'hfe);
    cmp(gdiv, 9'h01d);
    wr(ADDR_RED2_GAIN, 8'h33);
    cmp(cfg.red2_gain, 8'h33);
  endtask : t_access
  // every range code, each setup bit both ways, ticks per four master periods
  task automatic t_setup();
    logic [7:0] v [0:3];
    int n;
    v = '{8'h00, 8'hf4, 8'h59, 8'hae};
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_ANALOG_SETUP, v[k]);
      rd(ADDR_ANALOG_SETUP, v[k]);
      cmp(cfg[$bits(cfg)-1 -: 8], v[k]);
      cmp(sh3v, !v[k][1]);
      n = 0;
      repeat (64)
      begin
        @(posedge clk);
        #2;
        if (conv_en === 1'b1 && tx_en === 1'b1)
          n++;
      end
      cmp(16'(n), v[k][0] ? 16'h0008 : 16'h0004);
    end
  endtask : t_setup
  task automatic t_srcsel();
    logic [1:0] seen;
    pins = 2'b10;
    wr(ADDR_SAMPLING_SRC, 8'h77);
    cmp(sclk_out, 2'b10);
    pins = 2'b00;
    wr(ADDR_SAMPLING_SRC, RST_SAMPLING_SRC);
    seen = 2'b00;
    repeat (64)
    begin
      @(posedge clk);
      #2;
      seen |= sclk_out;
    end
    cmp(seen, 2'b11);
  endtask : t_srcsel
  task automatic t_soft();
    int c0;
    wr(ADDR_RED1_GAIN, 8'h44);
    c0 = fsm_pulses;
    wr(ADDR_SOFT_RESET, 8'h02);
    cmp(16'(fsm_pulses - c0), 16'h0001);
    rd(ADDR_RED1_GAIN, 8'h44);
    rd(ADDR_SOFT_RESET, 8'h00);
    wr(ADDR_SOFT_RESET, 8'h01);
    cmp(16'(fsm_pulses - c0), 16'h0002);
    rd(ADDR_RED1_GAIN, RST_GAIN);
    rd(ADDR_ANALOG_SETUP, RST_ANALOG_SETUP);
  endtask : t_soft
  // flip inputs after the unused edge; only the chosen edge may take them
  task automatic t_edges();
    for (int e = 0; e < 2; e++)
    begin
      wr(ADDR_ANALOG_SETUP, e ? 8'hb3 : 8'h83);
      if (e)
        @(posedge mclk);
      else
        @(negedge mclk);
      repeat (4) @(posedge clk);
      #2;
      clamp_in = ~clamp_in;
      dig_in = ~dig_in;
      repeat (5) @(posedge clk);
      #2;
      cmp({clamp_s, dig_s}, 5'(~{clamp_in, dig_in}));
      repeat (6) @(posedge clk);
      #2;
      cmp({clamp_s, dig_s}, {clamp_in, dig_in});
    end
  endtask : t_edges
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    t_defaults();
    t_access();
    t_setup();
    t_srcsel();
    t_soft();
    t_edges();
    give_verdict();
  end
  // watchdog, well above the expected run of some six thousand cycles
  initial
  begin
    #1000000;
    errors++;
    give_verdict();
  end
endmodule : imaging_afe_config_regs_bench
